// ### logic/gpio_irq_regs.svh
// register indices, field layout and reset values of the pin interrupt and wake block
// ============================================================================
// Overview of operation
// (R01) writing one to an upper-Y clear bit clears that pin's pending; zero does nothing
// (R02) raw status bits of X and lower Y show pending conditions, read-only, reset zero; here a one written to them clears that pending
// (R03) upper-Y raw status shows Y8..Y11 in bits 3:0, bits 7:4 reserved
// (R04) masked status bit is one only when the pin is pending and enabled
// (R05) upper-Y masked status carries Y8..Y11 in bits 3:0, rest reserved
// (R06) a set wake bit lets pin activity wake the device; reset gives no wake
// (R07) X and lower-Y wake bits map one bit per pin, bit n to pin n
// (R08) upper-Y wake bit 3 is Y11 down to bit 0 for Y8, 7:4 reserved
// (R09) per-pin enable gates raw pending into masked status; reset all disabled
// (R10) per-pin polarity bit: zero falling, one rising; reset all ones
// (R11) per-pin dual-edge bit makes both transitions raise a pending
// (R12) raw pending stays set until cleared; irq output high while any masked bit set
`ifndef GPIO_IRQ_REGS_SVH
`define GPIO_IRQ_REGS_SVH

// ============================================================================
// register indices; byte address on the bus is four times the index
`define IDX_DUAL_X      8'hCC
`define IDX_DUAL_YL     8'hCD
`define IDX_DUAL_YH     8'hCE
`define IDX_POL_X       8'hCF
`define IDX_POL_YL      8'hD0
`define IDX_POL_YH      8'hD1
`define IDX_EN_X        8'hD2
`define IDX_EN_YL       8'hD3
`define IDX_EN_YH       8'hD4
`define IDX_RAW_X       8'hD6
`define IDX_RAW_YL      8'hD7
`define IDX_RAW_YH      8'hD8
`define IDX_MSK_X       8'hD9
`define IDX_MSK_YL      8'hDA
`define IDX_MSK_YH      8'hDB
`define IDX_CLR_X       8'hDC
`define IDX_CLR_YL      8'hDD
`define IDX_CLR_YH      8'hDE
`define IDX_WAKE_X      8'hE9
`define IDX_WAKE_YL     8'hEA
`define IDX_WAKE_YH     8'hEB
`define IDX_EVT_STATUS  8'hF0
`define IDX_EVT_MASK    8'hF1

// ============================================================================
// field layout and reset values
`define PIN_COUNT       20
`define X_LSB           0
`define YL_LSB          8
`define YH_LSB          16
`define RST_POL         20'hFFFFF
`define RST_ZERO        20'h00000
`define EVT_WAKE_BIT    0
`define EVT_PIN_BIT     1

`endif

// ### logic/gpio_irq_pkg.sv
// types shared by the pin interrupt and wake block
package gpio_irq_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef struct packed {
    logic pol;
    logic dual;
    logic wake;
  } pin_cfg_t;
  typedef enum logic {ST_WAIT, ST_ANSWER} bus_phase_t;
endpackage

// ### logic/reg_access_if.sv
// register access strobe and data between the bus port and the register file
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  logic                  wr;
  gpio_irq_pkg::reg_byte_t idx;
  gpio_irq_pkg::reg_byte_t wdata;
  gpio_irq_pkg::reg_byte_t rdata;
  modport initiator (output wr, output idx, output wdata, input rdata);
  modport target (input wr, input idx, input wdata, output rdata);
endinterface
`default_nettype wire

// ### logic/pin_event_cell.sv
// edge detection and sticky pending flag for one pin
`timescale 1ns/1ps
`default_nettype none
module pin_event_cell (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_b,
  input  wire logic                   i_clk_en,
  input  wire logic                   i_pin,
  input  wire gpio_irq_pkg::pin_cfg_t i_cfg,
  input  wire logic                   i_clear,
  output logic                        o_raw,
  output logic                        o_wake_hit
);
  logic prev_reg;
  logic armed_reg;
  logic raw_reg;
  logic rise;
  logic fall;
  logic hit;

  // no edge is seen before the first sample, so a pin high at reset is quiet
  assign rise = armed_reg & i_pin & ~prev_reg;
  assign fall = armed_reg & ~i_pin & prev_reg;
  // see (R10) see (R11)
  assign hit  = i_cfg.dual ? (rise | fall) : (i_cfg.pol ? rise : fall);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      prev_reg  <= 1'b0;
      armed_reg <= 1'b0;
    end else if (i_clk_en) begin
      prev_reg  <= i_pin;
      armed_reg <= 1'b1;
    end
  end

  // a new edge in the clearing cycle wins, so no event is lost
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      raw_reg <= 1'b0;
    end else if (i_clk_en) begin
      raw_reg <= hit | (raw_reg & ~i_clear); // see (R12) see (R01)
    end
  end

  assign o_raw      = raw_reg;
  assign o_wake_hit = (rise | fall) & i_cfg.wake; // see (R06)

  AST_SET_WINS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see (R12)
    (i_clk_en && hit) |=> raw_reg)
    else $error("pending lost on a detected edge");
  AST_CLEAR_ONE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see (R01)
    (i_clk_en && i_clear && !hit) |=> !raw_reg)
    else $error("pending not cleared");
  AST_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see (R12)
    (raw_reg && !i_clear) |=> raw_reg)
    else $error("pending dropped without a clear");
  AST_RISE_ONLY: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see (R10)
    (i_clk_en && !raw_reg && !i_cfg.dual && i_cfg.pol && fall) |=> !raw_reg)
    else $error("falling edge set pending in rising mode");
endmodule
`default_nettype wire

// ### logic/avl_reg_port.sv
// Avalon-MM slave front end with one wait state per access
`timescale 1ns/1ps
`default_nettype none
module avl_reg_port (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_clk_en,
  input  wire logic [9:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  reg_access_if.initiator  acc
);
  gpio_irq_pkg::bus_phase_t phase_reg;
  logic                     req;

  assign req       = i_avs_read | i_avs_write;
  assign acc.idx   = i_avs_address[9:2];
  assign acc.wdata = i_avs_writedata[7:0];
  // the write lands at the edge where the master sees waitrequest low
  assign acc.wr    = i_clk_en & i_avs_write & i_avs_byteenable[0] & (phase_reg == gpio_irq_pkg::ST_ANSWER);

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      phase_reg         <= gpio_irq_pkg::ST_WAIT;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
    end else if (i_clk_en) begin
      unique case (phase_reg)
        gpio_irq_pkg::ST_WAIT: begin
          if (req) begin
            phase_reg         <= gpio_irq_pkg::ST_ANSWER;
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata    <= {24'h00_0000, acc.rdata};
          end
        end
        gpio_irq_pkg::ST_ANSWER: begin
          phase_reg         <= gpio_irq_pkg::ST_WAIT;
          o_avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  AST_ONE_WAIT: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_clk_en && req && o_avs_waitrequest) |=> !o_avs_waitrequest)
    else $error("access not answered after one wait state");
endmodule
`default_nettype wire

// ### logic/gpio_irq_status_wake.sv
// pin interrupt status, enables and wake control for 20 pins behind an Avalon-MM slave
`timescale 1ns/1ps
`default_nettype none
`include "gpio_irq_regs.svh"
module gpio_irq_status_wake (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_clk_en,
  input  wire logic [9:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic [7:0]  i_x_group_pin,
  input  wire logic [11:0] i_y_group_pin,
  output logic             o_irq,
  output logic             o_wake
);
  // ==========================================================================
  // storage
  logic [19:0] pol_reg;
  logic [19:0] dual_reg;
  logic [19:0] pin_irq_enable_reg;
  logic [19:0] wake_reg;
  logic [1:0]  evt_status_reg;
  logic [1:0]  evt_mask_reg;
  logic [19:0] pins;
  logic [19:0] raw_pending;
  logic [19:0] masked_pending;
  logic [19:0] pending_clear;
  logic [19:0] wake_hits;
  logic        any_wake;
  logic        any_masked;
  logic [1:0]  evt_set;
  logic [1:0]  evt_clr;

  reg_access_if acc ();

  // ==========================================================================
  // bus port
  avl_reg_port u_port (
    .i_sys_clk         (i_sys_clk),
    .i_rst_b           (i_rst_b),
    .i_clk_en          (i_clk_en),
    .i_avs_address     (i_avs_address),
    .i_avs_read        (i_avs_read),
    .i_avs_write       (i_avs_write),
    .i_avs_writedata   (i_avs_writedata),
    .i_avs_byteenable  (i_avs_byteenable),
    .o_avs_readdata    (o_avs_readdata),
    .o_avs_waitrequest (o_avs_waitrequest),
    .acc               (acc.initiator)
  );

  // ==========================================================================
  // byte-wide write into one group of a 20-bit vector
  function automatic logic [19:0] put_group(
    input logic [19:0] cur,
    input logic [7:0]  idx,
    input logic [7:0]  ix,
    input logic [7:0]  iyl,
    input logic [7:0]  iyh,
    input logic [7:0]  d
  );
    logic [19:0] r;
    r = cur;
    if (idx == ix) begin
      r[`YL_LSB-1:`X_LSB] = d;
    end else if (idx == iyl) begin
      r[`YH_LSB-1:`YL_LSB] = d;
    end else if (idx == iyh) begin
      // upper four bits of the upper-Y byte are reserved and dropped
      r[`PIN_COUNT-1:`YH_LSB] = d[3:0];
    end
    return r;
  endfunction

  // ==========================================================================
  // configuration registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pol_reg <= `RST_POL;
    end else if (i_clk_en && acc.wr) begin
      pol_reg <= put_group(pol_reg, acc.idx, `IDX_POL_X, `IDX_POL_YL, `IDX_POL_YH, acc.wdata); // see (R10)
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      dual_reg <= `RST_ZERO;
    end else if (i_clk_en && acc.wr) begin
      dual_reg <= put_group(dual_reg, acc.idx, `IDX_DUAL_X, `IDX_DUAL_YL, `IDX_DUAL_YH, acc.wdata); // see (R11)
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      pin_irq_enable_reg <= `RST_ZERO;
    end else if (i_clk_en && acc.wr) begin
      pin_irq_enable_reg <= put_group(pin_irq_enable_reg, acc.idx, `IDX_EN_X, `IDX_EN_YL, `IDX_EN_YH,
                                      acc.wdata); // see (R09)
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      wake_reg <= `RST_ZERO;
    end else if (i_clk_en && acc.wr) begin
      wake_reg <= put_group(wake_reg, acc.idx, `IDX_WAKE_X, `IDX_WAKE_YL, `IDX_WAKE_YH,
                            acc.wdata); // see (R07) see (R08)
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      evt_mask_reg <= 2'h0;
    end else if (i_clk_en && acc.wr && acc.idx == `IDX_EVT_MASK) begin
      evt_mask_reg <= acc.wdata[1:0];
    end
  end

  // ==========================================================================
  // clears: a one written to the clear register, or to the raw status itself
  always_comb begin
    pending_clear = 20'h00000;
    if (acc.wr) begin
      pending_clear = put_group(20'h00000, acc.idx, `IDX_CLR_X, `IDX_CLR_YL, `IDX_CLR_YH,
                                acc.wdata); // see (R01)
      pending_clear = pending_clear | put_group(20'h00000, acc.idx, `IDX_RAW_X, `IDX_RAW_YL,
                                                `IDX_RAW_YH, acc.wdata);
    end
  end

  // ==========================================================================
  // per-pin detectors
  assign pins = {i_y_group_pin, i_x_group_pin};

  for (genvar g = 0; g < `PIN_COUNT; g++) begin : g_pin
    gpio_irq_pkg::pin_cfg_t cfg;
    assign cfg.pol  = pol_reg[g];
    assign cfg.dual = dual_reg[g];
    assign cfg.wake = wake_reg[g];
    pin_event_cell u_cell (
      .i_sys_clk  (i_sys_clk),
      .i_rst_b    (i_rst_b),
      .i_clk_en   (i_clk_en),
      .i_pin      (pins[g]),
      .i_cfg      (cfg),
      .i_clear    (pending_clear[g]),
      .o_raw      (raw_pending[g]),
      .o_wake_hit (wake_hits[g])
    );
  end

  assign masked_pending = raw_pending & pin_irq_enable_reg; // see (R04) see (R09)
  assign any_masked     = |masked_pending;
  assign any_wake       = |wake_hits; // see (R06)

  // ==========================================================================
  // block event status: sticky, write one to clear, set wins over clear
  assign evt_set = {any_masked, any_wake};
  assign evt_clr = (acc.wr && acc.idx == `IDX_EVT_STATUS) ? acc.wdata[1:0] : 2'h0;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      evt_status_reg <= 2'h0;
    end else if (i_clk_en) begin
      evt_status_reg <= evt_set | (evt_status_reg & ~evt_clr);
    end
  end

  // ==========================================================================
  // outputs; both lag their cause by one clock
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_irq <= 1'b0;
    end else if (i_clk_en) begin
      o_irq <= any_masked | (|(evt_status_reg & evt_mask_reg)); // see (R12)
    end
  end

  // one-cycle wake pulse for the power controller
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_wake <= 1'b0;
    end else if (i_clk_en) begin
      o_wake <= any_wake; // see (R06)
    end
  end

  // ==========================================================================
  // read mux; reserved bits read as zero
  always_comb begin
    acc.rdata = 8'h00;
    unique case (acc.idx)
      `IDX_DUAL_X:     acc.rdata = dual_reg[7:0];
      `IDX_DUAL_YL:    acc.rdata = dual_reg[15:8];
      `IDX_DUAL_YH:    acc.rdata = {4'h0, dual_reg[19:16]};
      `IDX_POL_X:      acc.rdata = pol_reg[7:0];
      `IDX_POL_YL:     acc.rdata = pol_reg[15:8];
      `IDX_POL_YH:     acc.rdata = {4'h0, pol_reg[19:16]};
      `IDX_EN_X:       acc.rdata = pin_irq_enable_reg[7:0];
      `IDX_EN_YL:      acc.rdata = pin_irq_enable_reg[15:8];
      `IDX_EN_YH:      acc.rdata = {4'h0, pin_irq_enable_reg[19:16]};
      `IDX_RAW_X:      acc.rdata = raw_pending[7:0]; // see (R02)
      `IDX_RAW_YL:     acc.rdata = raw_pending[15:8]; // see (R02)
      `IDX_RAW_YH:     acc.rdata = {4'h0, raw_pending[19:16]}; // see (R03)
      `IDX_MSK_X:      acc.rdata = masked_pending[7:0]; // see (R04)
      `IDX_MSK_YL:     acc.rdata = masked_pending[15:8]; // see (R04)
      `IDX_MSK_YH:     acc.rdata = {4'h0, masked_pending[19:16]}; // see (R05)
      `IDX_WAKE_X:     acc.rdata = wake_reg[7:0]; // see (R07)
      `IDX_WAKE_YL:    acc.rdata = wake_reg[15:8]; // see (R07)
      `IDX_WAKE_YH:    acc.rdata = {4'h0, wake_reg[19:16]}; // see (R08)
      `IDX_EVT_STATUS: acc.rdata = {6'h00, evt_status_reg};
      `IDX_EVT_MASK:   acc.rdata = {6'h00, evt_mask_reg};
      default:         acc.rdata = 8'h00;
    endcase
  end

  // ==========================================================================
  // checks
  AST_MASKED_GATE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see (R04)
    masked_pending == (raw_pending & pin_irq_enable_reg) && (|masked_pending == any_masked))
    else $error("masked status disagrees with raw and enable");
  AST_IRQ_FOLLOWS: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see (R12)
    (i_clk_en && any_masked) |=> o_irq)
    else $error("irq not raised for masked pending");
  AST_IRQ_QUIET: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see (R12)
    (i_clk_en && !any_masked && !(|(evt_status_reg & evt_mask_reg))) |=> !o_irq)
    else $error("irq high with nothing pending");
  AST_WAKE_NEEDS_EN: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see (R06)
    (i_clk_en && wake_reg == 20'h00000) |=> !o_wake)
    else $error("wake with no wake bit set");
  AST_RST_POL: assert property (@(posedge i_sys_clk) // see (R10)
    $rose(i_rst_b) |-> pol_reg == `RST_POL && pin_irq_enable_reg == `RST_ZERO)
    else $error("configuration reset values wrong");
  AST_RAW_RESET: assert property (@(posedge i_sys_clk) // see (R02)
    $rose(i_rst_b) |-> raw_pending == 20'h00000 && !o_irq)
    else $error("raw status not zero after reset");
  AST_YH_RESERVED: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see (R03)
    (acc.idx == `IDX_RAW_YH || acc.idx == `IDX_MSK_YH || acc.idx == `IDX_WAKE_YH) |-> acc.rdata[7:4] == 4'h0)
    else $error("reserved bits not zero");
  AST_WAKE_WRITE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b) // see (R08)
    (acc.wr && acc.idx == `IDX_WAKE_YH) |=> wake_reg[19:16] == $past(acc.wdata[3:0]))
    else $error("upper wake byte not stored");
endmodule
`default_nettype wire

// ### verification/pin_stim.sv
// far-side model: pin levels driven toward the block, changed just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module pin_stim (
  input  wire logic   i_sys_clk,
  output logic [7:0]  o_x_group_pin,
  output logic [11:0] o_y_group_pin
);
  initial begin
    o_x_group_pin = 8'h00;
    o_y_group_pin = 12'h000;
  end

  // ==========================================================================
  // drive
  // pins are synchronous to the clock; of the three edges, the first samples and sets pending, the second raises irq
  task automatic drive(input logic [7:0] x, input logic [11:0] y);
    @(posedge i_sys_clk);
    o_x_group_pin <= x;
    o_y_group_pin <= y;
    repeat (3) @(posedge i_sys_clk);
  endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench for the pin interrupt status and wake block
`timescale 1ns/1ps
`default_nettype none
`include "gpio_irq_regs.svh"
module testbench;
  localparam int TIMEOUT_CYCLES = 20000;
  logic                    sys_clk;
  logic                    rst_b;
  logic                    clk_en;
  logic [9:0]              avs_address;
  logic                    avs_read;
  logic                    avs_write;
  logic [31:0]             avs_writedata;
  logic [3:0]              avs_byteenable;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest;
  logic [7:0]              x_pin;
  logic [11:0]             y_pin;
  logic                    irq;
  logic                    wake;
  logic [19:0]             lv;
  int                      error_cnt;
  int                      n_tests;
  int                      cycle_cnt;
  int                      wake_cnt;
  gpio_irq_pkg::reg_byte_t rd_val;

  gpio_irq_status_wake uut (
    .i_sys_clk         (sys_clk),
    .i_rst_b           (rst_b),
    .i_clk_en          (clk_en),
    .i_avs_address     (avs_address),
    .i_avs_read        (avs_read),
    .i_avs_write       (avs_write),
    .i_avs_writedata   (avs_writedata),
    .i_avs_byteenable  (avs_byteenable),
    .o_avs_readdata    (avs_readdata),
    .o_avs_waitrequest (avs_waitrequest),
    .i_x_group_pin     (x_pin),
    .i_y_group_pin     (y_pin),
    .o_irq             (irq),
    .o_wake            (wake)
  );

  pin_stim pins (
    .i_sys_clk     (sys_clk),
    .o_x_group_pin (x_pin),
    .o_y_group_pin (y_pin)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycle_cnt <= cycle_cnt + 1;
    if (wake === 1'b1) begin
      wake_cnt <= wake_cnt + 1;
    end
    if (cycle_cnt == TIMEOUT_CYCLES) begin
      error_cnt++;
      $display("Error at %0t: run did not finish", $time);
      test_done();
    end
  end

  // ==========================================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] id);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: item %h got %h expected %h", $time, id, got, exp);
    end
  endtask

  // one Avalon access; the request holds until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
    int n;
    @(posedge sys_clk);
    avs_address    <= {idx, 2'b00};
    avs_read       <= ~wr;
    avs_write      <= wr;
    avs_writedata  <= {24'h000000, d};
    avs_byteenable <= be;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      error_cnt++;
      $display("Error at %0t: no bus answer", $time);
    end
    rd_val = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask

  // reserved bits are masked off, their read value is not defined
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [7:0] msk);
    bus(1'b0, idx, 8'h00, 4'hF);
    chk(rd_val & msk, exp, idx);
  endtask

  task automatic tog(input int p);
    lv[p] = ~lv[p];
    pins.drive(lv[7:0], lv[19:8]);
  endtask

  task automatic clr_all();
    wr(`IDX_CLR_X, 8'hFF);
    wr(`IDX_CLR_YL, 8'hFF);
    wr(`IDX_CLR_YH, 8'h0F);
  endtask

  task automatic wake_try(input int p, input logic exp);
    wake_cnt = 0;
    tog(p);
    chk({7'h00, wake_cnt > 0}, {7'h00, exp}, 8'hEE);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset();
    chk({6'h00, irq, wake}, 8'h00, 8'hFF);
    rd(`IDX_RAW_X, 8'h00, 8'hFF);
    rd(`IDX_RAW_YL, 8'h00, 8'hFF);
    rd(`IDX_RAW_YH, 8'h00, 8'h0F);
    rd(`IDX_MSK_X, 8'h00, 8'hFF);
    rd(`IDX_MSK_YL, 8'h00, 8'hFF);
    rd(`IDX_MSK_YH, 8'h00, 8'h0F);
    rd(`IDX_WAKE_X, 8'h00, 8'hFF);
    rd(`IDX_WAKE_YL, 8'h00, 8'hFF);
    rd(`IDX_WAKE_YH, 8'h00, 8'h0F);
    rd(`IDX_EN_X, 8'h00, 8'hFF);
    rd(`IDX_POL_X, 8'hFF, 8'hFF);
    rd(`IDX_POL_YL, 8'hFF, 8'hFF);
    rd(`IDX_POL_YH, 8'h0F, 8'h0F);
    rd(`IDX_DUAL_YH, 8'h00, 8'h0F);
    wr(`IDX_RAW_X, 8'h55);
    rd(`IDX_RAW_X, 8'h00, 8'hFF);
    bus(1'b1, `IDX_WAKE_X, 8'hFF, 4'h0);
    rd(`IDX_WAKE_X, 8'h00, 8'hFF);
    wr(8'h10, 8'hFF);
    rd(8'h10, 8'h00, 8'hFF);
    $display("test reset done");
  endtask

  task automatic t_wake();
    for (int i = 0; i < 8; i++) begin
      wr(`IDX_WAKE_X, 8'h01 << i);
      rd(`IDX_WAKE_X, 8'h01 << i, 8'hFF);
      wr(`IDX_WAKE_YL, 8'h80 >> i);
      rd(`IDX_WAKE_YL, 8'h80 >> i, 8'hFF);
    end
    wr(`IDX_WAKE_YH, 8'h05);
    rd(`IDX_WAKE_YH, 8'h05, 8'h0F);
    wr(`IDX_WAKE_X, 8'h80);
    wr(`IDX_WAKE_YL, 8'h00);
    wake_try(7, 1'b1);
    wake_try(6, 1'b0);
    wr(`IDX_WAKE_X, 8'h00);
    wake_try(7, 1'b0);
    rd(`IDX_EVT_STATUS, 8'h01, 8'h01);
    wr(`IDX_EVT_STATUS, 8'h01);
    rd(`IDX_EVT_STATUS, 8'h00, 8'h01);
    wr(`IDX_WAKE_YH, 8'h08);
    wake_try(19, 1'b1);
    wake_try(16, 1'b0);
    wr(`IDX_WAKE_YH, 8'h00);
    wr(`IDX_EVT_STATUS, 8'h01);
    clr_all();
    $display("test wake done");
  endtask

  task automatic t_edges();
    tog(0);
    rd(`IDX_RAW_X, 8'h01, 8'hFF);
    rd(`IDX_MSK_X, 8'h00, 8'hFF);
    chk({7'h00, irq}, 8'h00, 8'hFF);
    wr(`IDX_EN_X, 8'h01);
    rd(`IDX_MSK_X, 8'h01, 8'hFF);
    chk({7'h00, irq}, 8'h01, 8'hFF);
    tog(0);
    rd(`IDX_RAW_X, 8'h01, 8'hFF);
    wr(`IDX_CLR_X, 8'h01);
    rd(`IDX_RAW_X, 8'h00, 8'hFF);
    rd(`IDX_MSK_X, 8'h00, 8'hFF);
    chk({7'h00, irq}, 8'h00, 8'hFF);
    tog(0);
    wr(`IDX_CLR_X, 8'h01);
    tog(0);
    rd(`IDX_RAW_X, 8'h00, 8'hFF);
    wr(`IDX_POL_X, 8'h00);
    tog(0);
    rd(`IDX_RAW_X, 8'h00, 8'hFF);
    tog(0);
    rd(`IDX_RAW_X, 8'h01, 8'hFF);
    wr(`IDX_CLR_X, 8'h01);
    wr(`IDX_DUAL_X, 8'h01);
    tog(0);
    rd(`IDX_RAW_X, 8'h01, 8'hFF);
    wr(`IDX_CLR_X, 8'h01);
    tog(0);
    rd(`IDX_RAW_X, 8'h01, 8'hFF);
    wr(`IDX_EN_X, 8'h00);
    wr(`IDX_DUAL_X, 8'h00);
    wr(`IDX_POL_X, 8'hFF);
    clr_all();
    $display("test edges done");
  endtask

  task automatic t_ygroup();
    tog(8);
    rd(`IDX_RAW_YL, 8'h01, 8'hFF);
    wr(`IDX_EN_YL, 8'h01);
    rd(`IDX_MSK_YL, 8'h01, 8'hFF);
    wr(`IDX_CLR_YL, 8'h01);
    wr(`IDX_EN_YL, 8'h00);
    wr(`IDX_DUAL_YH, 8'h0F);
    for (int p = 16; p < 20; p++) begin
      tog(p);
    end
    rd(`IDX_RAW_YH, 8'h0F, 8'h0F);
    rd(`IDX_MSK_YH, 8'h00, 8'h0F);
    wr(`IDX_EN_YH, 8'h05);
    rd(`IDX_MSK_YH, 8'h05, 8'h0F);
    chk({7'h00, irq}, 8'h01, 8'hFF);
    wr(`IDX_CLR_YH, 8'h0A);
    rd(`IDX_RAW_YH, 8'h05, 8'h0F);
    wr(`IDX_CLR_YH, 8'h04);
    rd(`IDX_RAW_YH, 8'h01, 8'h0F);
    chk({7'h00, irq}, 8'h01, 8'hFF);
    // frozen block keeps its irq level while a pin moves
    clk_en <= 1'b0;
    tog(8);
    chk({7'h00, irq}, 8'h01, 8'hFF);
    clk_en <= 1'b1;
    wr(`IDX_CLR_YH, 8'h01);
    rd(`IDX_RAW_YH, 8'h00, 8'h0F);
    rd(`IDX_MSK_YH, 8'h00, 8'h0F);
    chk({7'h00, irq}, 8'h00, 8'hFF);
    $display("test y group done");
  endtask

  // ==========================================================================
  // closing report
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    rst_b          = 1'b0;
    clk_en         = 1'b1;
    avs_address    = 10'h000;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h00000000;
    avs_byteenable = 4'h0;
    lv             = 20'h00000;
    error_cnt      = 0;
    n_tests        = 0;
    cycle_cnt      = 0;
    wake_cnt       = 0;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_reset();
    t_wake();
    t_edges();
    t_ygroup();
    test_done();
  end
endmodule
`default_nettype wire
